// >>> pkg/fus_pkg.sv
// Constants and carrier types for the flash update sequencer
package fus_pkg;
    localparam logic [7:0] FUS_CMD_START = 8'h10;
    localparam logic [7:0] FUS_CMD_ERASE = 8'h11;
    localparam logic [7:0] FUS_CMD_WRITE = 8'h12;
    localparam logic [7:0] FUS_READY_BYTE = 8'h55;
    localparam logic [7:0] FUS_BLK_LIMIT = 8'h26;
    localparam logic [7:0] FUS_BLK_FIRST_SMALL = 8'h1e;
    localparam int FUS_LARGE_BLOCKS = 30;
    localparam int FUS_SMALL_BLOCKS = 8;
    localparam logic [31:0] FUS_LARGE_BASE = 32'h00f8_0000;
    localparam logic [31:0] FUS_SMALL_BASE = 32'h00ff_8000;
    localparam logic [31:0] FUS_LARGE_SIZE = 32'h0000_4000;
    localparam logic [31:0] FUS_SMALL_SIZE = 32'h0000_1000;
    localparam logic [7:0] FUS_READ_TOP = 8'hff;
    localparam logic [7:0] FUS_PROG_ALIGN = 8'h00;
    localparam logic [15:0] FUS_D_NORMAL = 16'h00ff;
    localparam logic [15:0] FUS_D_PCLK0 = 16'h00e9;
    localparam logic [15:0] FUS_D_PCLK1 = 16'h0003;
    localparam logic [15:0] FUS_D_PCLK_VAL = 16'h0f0f;
    localparam logic [15:0] FUS_D_CONFIRM = 16'h00d0;
    localparam logic [15:0] FUS_D_PROG0 = 16'h00e8;
    localparam logic [15:0] FUS_D_PROG1 = 16'h0080;
    localparam logic [15:0] FUS_D_ERASE = 16'h0020;
    localparam logic [15:0] FUS_D_CLRSTAT = 16'h0050;
    localparam int FUS_PCLK_WRITES = 6;
    localparam int FUS_PROG_WRITES = 131;
    localparam int FUS_PROG_WORDS = 128;
    localparam logic [3:0] FUS_IND_ALL_OFF = 4'hf;
    localparam logic [3:0] FUS_IND_DONE = 4'he;
    localparam logic [3:0] FUS_IND_ERR_CMD = 4'hd;
    localparam logic [3:0] FUS_IND_ERR_BLK = 4'hb;
    localparam logic [3:0] FUS_IND_ERR_FLASH = 4'h7;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [15:0] data;
    } fus_fwr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fus_byte_t;
endpackage : fus_pkg

// >>> design/fus_sequencer.sv
// Flash update sequencer: command decode, flash command writes, indicators
`timescale 1ns/1ps
// Function
// RULE_01: Indicator outputs are active low: low lights, high darkens.
// RULE_02: Indicators on port0 bits 2,3,5 and port3 bit 4; direction bits set.
// RULE_03: Handshake shown on a dedicated busy output toward the master.
// RULE_04: After each handled item, send ready byte 55h.
// RULE_05: Master waits for the ready byte before sending more.
// RULE_06: Thirty 16 KB and eight 4 KB blocks; erase whole blocks.
// RULE_07: Program in 256-byte units starting at low byte 00h.
// RULE_08: Large blocks from 00F80000h, 4000h apart, highest number lowest; code puts block 00h lowest, addresses ascending with number.
// RULE_09: Small blocks from 00FF8000h, 1000h apart, descending numbers; code puts 1Eh at 00FF8000h, addresses ascending with number.
// RULE_10: Read view address is program view with top byte FFh.
// RULE_11: Normal mode: one write of FFh to command address.
// RULE_12: Clock notify: E9h, 03h, 0F0Fh three times, D0h.
// RULE_13: Program: 131 writes, E8h, 80h first, D0h last.
// RULE_14: 128 data words in order, first to destination, rest to command.
// RULE_15: Erase: 20h to command address, D0h inside the block.
// RULE_16: Status clear: one write of 50h to command address.
// RULE_17: Writes use command, destination and erase-block addresses.
// RULE_18: Accept 10h start, 11h erase, 12h program; reject others.
// RULE_19: Block selector 26h or above signals an error and stops.
// RULE_20: No new sequence until erase or program completes or times out.
module fus_sequencer #(
    parameter logic [31:0] CMD_ADDR = 32'h00f8_0000,
    parameter int WAIT_CYCLES = 100000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire fus_pkg::fus_byte_t rx_byte,
    input wire logic tx_ready,
    input wire logic [15:0] wdata_word,
    input wire logic fl_done,
    input wire logic fl_error,
    output fus_pkg::fus_byte_t tx_byte,
    output logic wdata_pop,
    output fus_pkg::fus_fwr_t fl_write,
    output logic busy_port,
    output logic [7:0] port0_output_value,
    output logic [7:0] port0_direction,
    output logic [7:0] port3_output_value,
    output logic [7:0] port3_direction,
    output logic [31:0] read_view_addr
);
    import fus_pkg::*;

    typedef enum logic [11:0] {
        FUS_IDLE = 12'h001,
        FUS_CMD = 12'h002,
        FUS_BLK = 12'h004,
        FUS_MODE = 12'h008,
        FUS_PCLK = 12'h010,
        FUS_ERASE = 12'h020,
        FUS_PROG = 12'h040,
        FUS_WAIT = 12'h080,
        FUS_CLR = 12'h100,
        FUS_READY = 12'h200,
        FUS_DONE = 12'h400,
        FUS_ERR = 12'h800
    } fus_state_t;

    typedef enum logic [1:0] {
        FUS_OP_NONE = 2'h0,
        FUS_OP_ERASE = 2'h1,
        FUS_OP_PROG = 2'h2
    } fus_op_t;

    // Program-view base of a block selector
    function automatic logic [31:0] fus_block_base(input logic [7:0] sel);
        logic [31:0] idx;
        idx = {24'h0, sel};
        if (sel < FUS_BLK_FIRST_SMALL) begin // RULE_06
            fus_block_base = FUS_LARGE_BASE + idx * FUS_LARGE_SIZE; // RULE_08
        end else begin
            fus_block_base = FUS_SMALL_BASE
                + (idx - {24'h0, FUS_BLK_FIRST_SMALL}) * FUS_SMALL_SIZE; // RULE_09
        end
    endfunction : fus_block_base

    function automatic logic [31:0] fus_block_size(input logic [7:0] sel);
        fus_block_size = (sel < FUS_BLK_FIRST_SMALL) ? FUS_LARGE_SIZE : FUS_SMALL_SIZE; // RULE_06
    endfunction : fus_block_size

    localparam logic [7:0] STEP_W = 8'h01;

    fus_state_t state_q, state_d;
    fus_op_t op_q, op_d;
    logic [7:0] blk_q, blk_d;
    logic [7:0] step_q, step_d;
    logic [31:0] dest_q, dest_d;
    logic [31:0] wait_q, wait_d;
    logic [3:0] ind_q, ind_d;
    logic busy_q, busy_d;
    fus_byte_t tx_q, tx_d;
    fus_fwr_t fw_q, fw_d;
    logic pop_q, pop_d;
    logic pclk_done_q, pclk_done_d;
    logic [31:0] blk_base;

    assign blk_base = fus_block_base(blk_q);

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        blk_d = blk_q;
        step_d = step_q;
        dest_d = dest_q;
        wait_d = wait_q;
        ind_d = ind_q;
        busy_d = busy_q;
        tx_d = '0;
        fw_d = '0;
        pop_d = 1'b0;
        pclk_done_d = pclk_done_q;
        case (state_q)
            FUS_IDLE: begin
                busy_d = 1'b0;
                if (rx_byte.valid) begin
                    busy_d = 1'b1;
                    if (rx_byte.data == FUS_CMD_START) begin // RULE_18
                        state_d = FUS_READY;
                        state_d = FUS_MODE;
                        step_d = '0;
                    end else begin
                        ind_d = FUS_IND_ERR_CMD;
                        state_d = FUS_ERR;
                    end
                end
            end
            FUS_MODE: begin
                fw_d.valid = 1'b1;
                fw_d.addr = CMD_ADDR;
                fw_d.data = FUS_D_NORMAL; // RULE_11
                state_d = pclk_done_q ? FUS_READY : FUS_PCLK;
            end
            FUS_PCLK: begin
                fw_d.valid = 1'b1;
                fw_d.addr = CMD_ADDR; // RULE_17
                case (step_q)
                    8'h00: fw_d.data = FUS_D_PCLK0; // RULE_12
                    8'h01: fw_d.data = FUS_D_PCLK1;
                    8'h05: fw_d.data = FUS_D_CONFIRM;
                    default: fw_d.data = FUS_D_PCLK_VAL;
                endcase
                step_d = step_q + STEP_W;
                if (step_q == 8'(FUS_PCLK_WRITES - 1)) begin
                    step_d = '0;
                    pclk_done_d = 1'b1;
                    state_d = FUS_READY;
                end
            end
            FUS_CMD: begin
                busy_d = 1'b0;
                if (rx_byte.valid) begin
                    busy_d = 1'b1;
                    if (rx_byte.data == FUS_CMD_ERASE) begin // RULE_18
                        op_d = FUS_OP_ERASE;
                        state_d = FUS_BLK;
                    end else if (rx_byte.data == FUS_CMD_WRITE) begin
                        op_d = FUS_OP_PROG;
                        state_d = FUS_BLK;
                    end else begin
                        ind_d = FUS_IND_ERR_CMD;
                        state_d = FUS_ERR;
                    end
                end
            end
            FUS_BLK: begin
                if (rx_byte.valid) begin
                    if (rx_byte.data >= FUS_BLK_LIMIT) begin // RULE_19
                        ind_d = FUS_IND_ERR_BLK;
                        state_d = FUS_ERR;
                    end else begin
                        blk_d = rx_byte.data;
                        dest_d = fus_block_base(rx_byte.data);
                        step_d = '0;
                        state_d = (op_q == FUS_OP_ERASE) ? FUS_ERASE : FUS_PROG;
                    end
                end
            end
            FUS_ERASE: begin
                fw_d.valid = 1'b1;
                fw_d.addr = (step_q == '0) ? CMD_ADDR : blk_base; // RULE_15
                fw_d.data = (step_q == '0) ? FUS_D_ERASE : FUS_D_CONFIRM;
                step_d = step_q + STEP_W;
                if (step_q != '0) begin
                    wait_d = '0;
                    state_d = FUS_WAIT;
                end
            end
            FUS_PROG: begin
                // Pop one cycle ahead: the store only advances after it sees the registered pulse
                pop_d = (step_q >= STEP_W) && (step_q <= 8'(FUS_PROG_WORDS)); // RULE_14
                fw_d.valid = 1'b1;
                fw_d.addr = CMD_ADDR;
                if (step_q == 8'h00) begin
                    fw_d.data = FUS_D_PROG0; // RULE_13
                end else if (step_q == 8'h01) begin
                    fw_d.data = FUS_D_PROG1;
                end else if (step_q == 8'(FUS_PROG_WRITES - 1)) begin
                    fw_d.data = FUS_D_CONFIRM;
                    wait_d = '0;
                    state_d = FUS_WAIT;
                end else begin
                    fw_d.data = wdata_word; // RULE_14
                    if (step_q == 8'h02) begin
                        fw_d.addr = {dest_q[31:8], FUS_PROG_ALIGN}; // RULE_07
                    end
                end
                step_d = step_q + STEP_W;
            end
            FUS_WAIT: begin
                wait_d = wait_q + 32'h1;
                if (fl_error || wait_q == 32'(WAIT_CYCLES)) begin // RULE_20
                    ind_d = FUS_IND_ERR_FLASH;
                    state_d = FUS_ERR;
                end else if (fl_done) begin
                    state_d = FUS_CLR;
                end
            end
            FUS_CLR: begin
                fw_d.valid = 1'b1;
                fw_d.addr = CMD_ADDR;
                fw_d.data = FUS_D_CLRSTAT; // RULE_16
                if (op_q == FUS_OP_PROG) begin
                    dest_d = dest_q + 32'h100;
                end
                ind_d = FUS_IND_DONE;
                state_d = FUS_READY;
            end
            FUS_READY: begin
                if (tx_ready) begin
                    tx_d.valid = 1'b1;
                    tx_d.data = FUS_READY_BYTE; // RULE_04
                    busy_d = 1'b0; // RULE_03
                    state_d = FUS_CMD; // RULE_05
                end
            end
            FUS_ERR: begin
                busy_d = 1'b1;
            end
            default: begin
                state_d = FUS_ERR;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FUS_IDLE;
            op_q <= FUS_OP_NONE;
            blk_q <= '0;
            step_q <= '0;
            dest_q <= '0;
            wait_q <= '0;
            ind_q <= FUS_IND_ALL_OFF;
            busy_q <= 1'b1;
            tx_q <= '0;
            fw_q <= '0;
            pop_q <= 1'b0;
            pclk_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            blk_q <= blk_d;
            step_q <= step_d;
            dest_q <= dest_d;
            wait_q <= wait_d;
            ind_q <= ind_d;
            busy_q <= busy_d;
            tx_q <= tx_d;
            fw_q <= fw_d;
            pop_q <= pop_d;
            pclk_done_q <= pclk_done_d;
        end
    end

    logic [7:0] p0_q, p3_q, dir0_q, dir3_q;
    logic [31:0] rd_q;
    logic unused_size;
    assign unused_size = |fus_block_size(blk_q);

    // Indicators are active low: a 0 lights the lamp
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            p0_q <= 8'hff;
            p3_q <= 8'hff;
            dir0_q <= 8'h00;
            dir3_q <= 8'h00;
            rd_q <= '0;
        end else begin
            p0_q <= {2'b11, ind_q[2], 1'b1, ind_q[1], ind_q[0], 2'b11}; // RULE_01
            p3_q <= {3'b111, ind_q[3], 4'hf};
            dir0_q <= 8'h2c; // RULE_02
            dir3_q <= 8'h10;
            rd_q <= {FUS_READ_TOP, blk_base[23:0]}; // RULE_10
        end
    end

    assign tx_byte = tx_q;
    assign wdata_pop = pop_q;
    assign fl_write = fw_q;
    assign busy_port = busy_q;
    assign port0_output_value = p0_q;
    assign port0_direction = dir0_q;
    assign port3_output_value = p3_q;
    assign port3_direction = dir3_q;
    assign read_view_addr = rd_q;
endmodule : fus_sequencer

// >>> tb/fus_seq_checker.sv
// Port checker for the flash update sequencer
`timescale 1ns/1ps
module fus_seq_checker #(
    parameter logic [31:0] CMD_ADDR = 32'h00f8_0000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire fus_pkg::fus_byte_t tx_byte,
    input wire logic busy_port,
    input wire fus_pkg::fus_fwr_t fl_write,
    input wire logic [7:0] port0_direction,
    input wire logic [7:0] port3_direction,
    input wire logic [31:0] read_view_addr
);
    import fus_pkg::*;
    logic [7:0] wr_cnt_q;
    logic [7:0] wr_cnt_d;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Position inside a program burst; zero outside one
    always_comb begin
        wr_cnt_d = wr_cnt_q;
        if (wr_cnt_q == 8'h83)
            wr_cnt_d = 8'h00;
        else if (fl_write.valid && wr_cnt_q != 8'h00)
            wr_cnt_d = wr_cnt_q + 8'h01;
        if (fl_write.valid && fl_write.data == FUS_D_PROG0 && wr_cnt_q == 8'h00)
            wr_cnt_d = 8'h01;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            wr_cnt_q <= 8'h00;
        else
            wr_cnt_q <= wr_cnt_d;
    end
    ready_byte_a: assert property (tx_byte.valid |-> tx_byte.data == FUS_READY_BYTE)
        else $error("ready byte value wrong");
    busy_release_a: assert property (tx_byte.valid |-> ##[0:3] !busy_port)
        else $error("busy stays high after ready byte");
    port_dir_a: assert property ($past(rst_n) |-> port0_direction == 8'h2c && port3_direction == 8'h10)
        else $error("indicator pins not outputs");
    pe_window_a: assert property (fl_write.valid |-> fl_write.addr >= FUS_LARGE_BASE
        && fl_write.addr <= 32'h00ff_ffff) else $error("flash write outside window");
    erase_pair_a: assert property (fl_write.valid && fl_write.data == FUS_D_ERASE |=>
        fl_write.valid && fl_write.data == FUS_D_CONFIRM && fl_write.addr[11:0] == 12'h000)
        else $error("erase confirm missing");
    read_view_a: assert property (fl_write.valid && fl_write.data == FUS_D_CONFIRM
        && $past(fl_write.valid) && $past(fl_write.data) == FUS_D_ERASE
        |-> read_view_addr == {FUS_READ_TOP, fl_write.addr[23:0]}) else $error("read view wrong");
    normal_mode_a: assert property (fl_write.valid && fl_write.data == FUS_D_NORMAL |->
        fl_write.addr == CMD_ADDR ##[1:4] fl_write.valid && fl_write.data == FUS_D_PCLK0)
        else $error("mode write not followed by clock notify");
    clock_seq_a: assert property (fl_write.valid && fl_write.data == FUS_D_PCLK0 |->
        ##[1:4] fl_write.valid && fl_write.data == FUS_D_PCLK1
        ##[1:4] fl_write.valid && fl_write.data == FUS_D_PCLK_VAL
        ##[1:4] fl_write.valid && fl_write.data == FUS_D_PCLK_VAL
        ##[1:4] fl_write.valid && fl_write.data == FUS_D_PCLK_VAL
        ##[1:4] fl_write.valid && fl_write.data == FUS_D_CONFIRM) else $error("clock notify order");
    prog_end_a: assert property (fl_write.valid && wr_cnt_q == 8'h82 |->
        fl_write.data == FUS_D_CONFIRM && fl_write.addr == CMD_ADDR) else $error("program end");
    prog_dest_a: assert property (fl_write.valid && wr_cnt_q == 8'h02 |->
        fl_write.addr[7:0] == FUS_PROG_ALIGN) else $error("program unit misaligned");
    prog_cmd_a: assert property (fl_write.valid && wr_cnt_q > 8'h02 && wr_cnt_q < 8'h82 |->
        fl_write.addr == CMD_ADDR) else $error("program word address");
    clear_addr_a: assert property (fl_write.valid && fl_write.data == FUS_D_CLRSTAT |->
        fl_write.addr == CMD_ADDR) else $error("status clear address");
endmodule : fus_seq_checker

// >>> tb/fus_master_model.sv
// Master controller model: sends command bytes, paces on the ready byte
`timescale 1ns/1ps
module fus_master_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire fus_pkg::fus_byte_t tx_byte,
    output fus_pkg::fus_byte_t rx_byte,
    output logic tx_ready
);
    import fus_pkg::*;
    logic [2:0] cnt_q = 3'h0;
    int acks = 0;
    initial rx_byte = '0;
    initial tx_ready = 1'b1;
    // Slow mode stalls the transmitter half the time
    always @(posedge core_clk) begin
        cnt_q <= cnt_q + 3'h1;
        tx_ready <= !slow || cnt_q[2];
        if (tx_byte.valid && tx_byte.data == FUS_READY_BYTE)
            acks <= acks + 1;
    end
    // Idle data is inverted so a stale byte never looks valid
    task automatic send(input logic [7:0] b, input logic pace);
        int a0;
        a0 = acks;
        @(posedge core_clk) rx_byte <= {1'b1, b};
        @(posedge core_clk) rx_byte <= {1'b0, ~b};
        if (pace)
            for (int i = 0; i < 2000 && acks == a0; i++) @(posedge core_clk);
    endtask : send
endmodule : fus_master_model

// >>> tb/test_fus_sequencer.sv
// Self-checking testbench for the flash update sequencer
`timescale 1ns/1ps
module test_fus_sequencer;
    import fus_pkg::*;
    localparam logic [31:0] CA = 32'h00f8_0000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fl_done = 1'b0;
    logic fl_error = 1'b0;
    logic slow = 1'b0;
    logic fail_fl = 1'b0;
    logic [15:0] wdata_word = 16'h1000;
    logic [15:0] w0;
    fus_byte_t rx_byte, tx_byte;
    fus_fwr_t fl_write;
    logic tx_ready, wdata_pop, busy_port;
    logic [7:0] p0v, p0d, p3v, p3d;
    logic [31:0] read_view_addr;
    logic [47:0] seen[$];
    logic [47:0] exp_q[$];
    logic [7:0] sel_tab[4] = '{8'h1d, 8'h25, 8'h00, 8'h1e};
    logic [31:0] base_tab[4] = '{32'h00ff_4000, 32'h00ff_f000, 32'h00f8_0000, 32'h00ff_8000};
    int dly = 0;
    int cycles = 0;
    int n_errors = 0;
    int checks_done = 0;
    fus_sequencer #(.CMD_ADDR(CA), .WAIT_CYCLES(50)) u_dut (.core_clk, .rst_n, .rx_byte,
        .tx_ready, .wdata_word, .fl_done, .fl_error, .tx_byte, .wdata_pop, .fl_write,
        .busy_port, .port0_output_value(p0v), .port0_direction(p0d),
        .port3_output_value(p3v), .port3_direction(p3d), .read_view_addr);
    fus_master_model u_mst (.core_clk, .slow, .tx_byte, .rx_byte, .tx_ready);
    initial forever #25 core_clk = ~core_clk;
    // Flash array stand-in: answers every confirm write six cycles later
    always @(posedge core_clk) begin
        fl_done <= dly == 1 && !fail_fl;
        fl_error <= dly == 1 && fail_fl;
        dly <= (fl_write.valid && fl_write.data == FUS_D_CONFIRM) ? 5 : (dly > 0 ? dly - 1 : 0);
        if (fl_write.valid)
            seen.push_back({fl_write.addr, fl_write.data});
        if (wdata_pop)
            wdata_word <= wdata_word + 16'h0001;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop;
        end
    end
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic ex(input logic [31:0] a, input logic [15:0] d);
        exp_q.push_back({a, d});
    endtask : ex
    task automatic cmp_all;
        check(seen.size(), exp_q.size());
        foreach (exp_q[i]) check(seen[i], exp_q[i]);
        seen.delete();
        exp_q.delete();
    endtask : cmp_all
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        check(busy_port, 1'b1);
        check(p0v, 8'hff);
        seen.delete();
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check({p0d, p3d}, 16'h2c10);
    endtask : do_reset
    task automatic start_up;
        u_mst.send(FUS_CMD_START, 1'b1);
        ex(CA, FUS_D_NORMAL);
        ex(CA, FUS_D_PCLK0);
        ex(CA, FUS_D_PCLK1);
        repeat (3) ex(CA, FUS_D_PCLK_VAL);
        ex(CA, FUS_D_CONFIRM);
        cmp_all;
    endtask : start_up
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        do_reset;
        start_up;
        for (int k = 0; k < 4; k++) begin
            u_mst.send(FUS_CMD_ERASE, 1'b0);
            u_mst.send(sel_tab[k], 1'b1);
            ex(CA, FUS_D_ERASE);
            ex(base_tab[k], FUS_D_CONFIRM);
            ex(CA, FUS_D_CLRSTAT);
            cmp_all;
            check(read_view_addr, {8'hff, base_tab[k][23:0]});
        end
        slow <= 1'b1;
        w0 = wdata_word;
        u_mst.send(FUS_CMD_WRITE, 1'b0);
        u_mst.send(8'h1d, 1'b1);
        ex(CA, FUS_D_PROG0);
        ex(CA, FUS_D_PROG1);
        for (int i = 0; i < FUS_PROG_WORDS; i++) ex(i == 0 ? base_tab[0] : CA, w0 + 16'(i));
        ex(CA, FUS_D_CONFIRM);
        ex(CA, FUS_D_CLRSTAT);
        cmp_all;
        slow <= 1'b0;
        u_mst.send(FUS_CMD_ERASE, 1'b0);
        u_mst.send(FUS_BLK_LIMIT, 1'b0);
        repeat (30) @(posedge core_clk);
        check({p3v[4], p0v[5], p0v[3], p0v[2], 8'(seen.size())}, {FUS_IND_ERR_BLK, 8'h00});
        do_reset;
        u_mst.send(8'h13, 1'b0);
        repeat (30) @(posedge core_clk);
        check({p3v[4], p0v[5], p0v[3], p0v[2]}, FUS_IND_ERR_CMD);
        do_reset;
        start_up;
        fail_fl <= 1'b1;
        u_mst.send(FUS_CMD_ERASE, 1'b0);
        u_mst.send(8'h1d, 1'b0);
        repeat (40) @(posedge core_clk);
        check({p3v[4], p0v[5], p0v[3], p0v[2]}, FUS_IND_ERR_FLASH);
        report_and_stop;
    end
endmodule : test_fus_sequencer
bind fus_sequencer fus_seq_checker #(.CMD_ADDR(CMD_ADDR)) u_chk (.core_clk, .rst_n, .tx_byte,
    .busy_port, .fl_write, .port0_direction, .port3_direction, .read_view_addr);
